/* design/drive_binary_control_status.sv */
// Drive binary control, status and command words with AHB-Lite access
//
// Operation
// - Full-scale select 0 scales analog reference by first, 1 by second.
// - Reference source 1 takes mode reserved reference, 0 the user one.
// - Freeze bit holds applied reference; cleared, reference tracks input.
// - Left limit with negative demand ramps reference to zero, stop ramp.
// - Right limit with positive demand ramps reference to zero, stop ramp.
// - Stop request ramps reference to zero regardless of demand.
// - Window mode 0 compares motor minus reference, 1 motor speed.
// - At-speed is 1 only strictly between lower and upper threshold.
// - Overspeed is 1 when absolute motor speed exceeds threshold.
// - Zero-speed flags speed equal zero; forward flags positive speed.
// - Soft enable resets to 1; while 0 the drive cannot start.
// - Aux output carries torque when select 0, aux value when 1.
// - Digital reference 0 picks analog input, 1 a digital source.
// - Internal/frequency select 0 picks internal, 1 frequency reference.
// - Frequency format resets to 1: quadrature; 0 is pulse plus direction.
// - Encoder select codes 2 to 7 map to 4096 down to 128 output lines; 0 and 1 give 0.
// - Commands run only unlocked; reinit and offset-zero need extended menu.
// - Alarm clear wipes active and last codes, refused on checksum codes.
// - Mode defaults command runs only with reference source 0.
// - Global defaults resets parameters, clears checksum alarms, PLC stopped.
// - Store commands are refused while a checksum alarm is active.
// - Offset zero cancels measured offset only when below 200 mV.
// - Active alarm code shows current alarm, zero meaning none.
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/100ps

module drive_binary_control_status
    import drive_pkg::*;
(
    input  wire logic                 CLK_IN,
    input  wire logic                 RSTN_IN,
    input  wire logic                 HSEL_IN,
    input  wire logic [31:0]          HADDR_IN,
    input  wire logic [1:0]           HTRANS_IN,
    input  wire logic                 HWRITE_IN,
    input  wire logic [2:0]           HSIZE_IN,
    input  wire logic [31:0]          HWDATA_IN,
    input  wire logic                 HREADY_IN,
    output logic      [31:0]          HRDATA_OUT,
    output logic                      HREADYOUT_OUT,
    output logic                      HRESP_OUT,
    input  wire logic signed [15:0]   ANALOG_REF_IN,
    input  wire logic signed [15:0]   FREQ_REF_IN,
    input  wire logic signed [15:0]   RESERVED_REF_IN,
    input  wire logic signed [15:0]   MOTOR_SPEED_IN,
    input  wire logic signed [15:0]   TORQUE_IN,
    input  wire logic signed [15:0]   OFFSET_MV_IN,
    input  wire logic                 ALARM_VALID_IN,
    input  wire logic [7:0]           ALARM_CODE_IN,
    input  wire logic                 DOUT_OVERCURRENT_IN,
    input  wire logic                 START_REQ_IN,
    output logic signed [15:0]        SPEED_REF_OUT,
    output logic signed [15:0]        AUX_OUT,
    output logic                      DRIVE_RUN_OUT,
    output logic [12:0]               ENC_LINES_OUT,
    output logic                      FREQ_QUADRATURE_OUT,
    output speed_flags_type           SPEED_FLAGS_OUT,
    output cmd_pulse_type             CMD_PULSE_OUT
);

    // ------
    // Functions
    // ------
    function automatic logic is_cksum(input logic [7:0] code);
        is_cksum = (code == ALARM_CKS_PLC) || (code == ALARM_CKS_PAR);
    endfunction : is_cksum

    function automatic logic signed [16:0] sx(
        input logic signed [15:0] v);
        sx = {v[15], v};
    endfunction : sx

    function automatic logic [16:0] mag(input logic signed [15:0] v);
        logic signed [16:0] w;
        w   = sx(v);
        mag = w[16] ? 17'(-w) : 17'(w);
    endfunction : mag

    // Encoder simulation resolution, code is {sel2, sel1, sel0}
    function automatic logic [12:0] enc_lines(input logic [2:0] c);
        case (c)
            3'h2:    enc_lines = 13'h1000;
            3'h3:    enc_lines = 13'h0800;
            3'h4:    enc_lines = 13'h0400;
            3'h5:    enc_lines = 13'h0200;
            3'h6:    enc_lines = 13'h0100;
            3'h7:    enc_lines = 13'h0080;
            default: enc_lines = 13'h0000;
        endcase
    endfunction : enc_lines

    // ------
    // Storage
    // ------
    logic [15:0]        ctrl_q;
    logic [15:0]        io_q;
    logic [15:0]        sys_q;
    logic [15:0]        par_q [NUM_PAR];
    logic [7:0]         alm_act_q;
    logic [7:0]         alm_last_q;
    logic [7:0]         wr_addr_q;
    logic               wr_pend_q;
    logic [31:0]        rdata_q;
    ref_state_type      state_q;
    ref_state_type      state_d;
    logic signed [15:0] ref_q;
    logic [TICK_W-1:0]  tick_cnt_q;
    logic               tick;
    logic [15:0]        ramp_cnt_q;
    speed_flags_type    flags_q;
    logic               run_q;
    logic signed [15:0] aux_q;
    logic [12:0]        enc_q;
    cmd_pulse_type      cmd_q;

    // ------
    // AHB-Lite slave
    // ------
    // Zero wait states; a read issued right behind a write to the
    // same word returns the value from before that write.
    logic        req;
    logic [15:0] wd;
    logic        wr_ok;
    logic        unlocked;

    assign req           = HSEL_IN && HREADY_IN && HTRANS_IN[1];
    assign wd            = HWDATA_IN[15:0];
    assign HREADYOUT_OUT = 1'b1;
    assign HRESP_OUT     = 1'b0;
    assign HRDATA_OUT    = rdata_q;
    assign unlocked      = !sys_q[B_EDIT_LOCK];
    assign wr_ok         = wr_pend_q && unlocked;

    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end
        else
        begin
            wr_pend_q <= req && HWRITE_IN;
            wr_addr_q <= {HADDR_IN[7:2], 2'h0};
        end
    end

    logic [15:0] rd_word;
    logic [7:0]  ra;
    logic [3:0]  ridx;

    always_comb
    begin
        ra      = {HADDR_IN[7:2], 2'h0};
        ridx    = 4'(ra[5:2] - OFF_PAR_BASE[5:2]);
        rd_word = 16'h0000;
        case (ra)
            OFF_CTRL:     rd_word = ctrl_q;
            OFF_STATUS:   rd_word = {3'h0, run_q, 7'h00,
                                     alm_act_q == ALARM_NONE,
                                     flags_q};
            OFF_IOCFG:    rd_word = {io_q[15:5], DOUT_OVERCURRENT_IN,
                                     io_q[3:0]};
            OFF_SYS:      rd_word = sys_q;
            OFF_ALM_ACT:  rd_word = {8'h00, alm_act_q};
            OFF_ALM_LAST: rd_word = {8'h00, alm_last_q};
            default:
                if (ra >= OFF_PAR_BASE && ra < OFF_ALM_ACT)
                    rd_word = par_q[ridx];
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
            rdata_q <= 32'h0000_0000;
        else if (req && !HWRITE_IN)
            rdata_q <= {16'h0000, rd_word};
    end

    // ------
    // Command decode
    // ------
    logic       wr_sys;
    logic       wr_func;
    logic       wr_io;
    logic       ext;
    logic       c_alm_clr;
    logic       c_glob;
    logic       c_ofs;
    logic [3:0] widx;

    assign ext      = sys_q[B_EXT_MENU];
    assign wr_sys   = wr_pend_q && wr_addr_q == OFF_SYS && unlocked;
    assign wr_func  = wr_ok && wr_addr_q == OFF_FUNC;
    assign wr_io    = wr_ok && wr_addr_q == OFF_IOCFG;
    assign widx     = 4'(wr_addr_q[5:2] - OFF_PAR_BASE[5:2]);
    assign c_alm_clr = wr_sys && wd[B_ALM_CLR]
                       && !is_cksum(alm_act_q);
    assign c_glob   = wr_sys && wd[B_GLOB_DEF]
                      && !sys_q[B_PLC_RUN];
    assign c_ofs    = wr_func && wd[B_OFS_ZERO] && ext
                      && mag(OFFSET_MV_IN) < 17'(OFS_LIMIT_MV);

    // Commands are pulses, never stored, so they read back as 0
    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
            cmd_q <= '0;
        else
        begin
            cmd_q.serial_reinit   <= wr_io && wd[B_REINIT] && ext;
            cmd_q.mode_defaults   <= wr_sys && wd[B_MODE_DEF]
                                     && !ctrl_q[B_REF_SRC];
            cmd_q.global_defaults <= c_glob;
            cmd_q.store_program   <= wr_sys && wd[B_STORE_PRG]
                                     && !is_cksum(alm_act_q);
            cmd_q.store_params    <= wr_sys && wd[B_STORE_PAR]
                                     && !is_cksum(alm_act_q);
        end
    end
    assign CMD_PULSE_OUT = cmd_q;

    // ------
    // Control words
    // ------
    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
            ctrl_q <= CTRL_RESET;
        else if (wr_ok && wr_addr_q == OFF_CTRL)
            ctrl_q <= wd & CTRL_WMASK;
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
            io_q <= IO_RESET;
        else if (wr_io)
            io_q <= wd & IO_WMASK;
    end

    // Lock bit stays writable so software can always unlock again
    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
            sys_q <= SYS_RESET;
        else if (wr_pend_q && wr_addr_q == OFF_SYS)
            sys_q <= wd & SYS_WMASK;
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            for (int i = 0; i < NUM_PAR; i++)
                par_q[i] <= PAR_DEFAULT[i];
        end
        else if (c_glob)
        begin
            for (int i = 0; i < NUM_PAR; i++)
                par_q[i] <= PAR_DEFAULT[i];
        end
        else if (c_ofs)
            par_q[P_REF_OFS] <= 16'(-OFFSET_MV_IN);
        else if (wr_ok && wr_addr_q >= OFF_PAR_BASE
                 && wr_addr_q < OFF_ALM_ACT)
            par_q[widx] <= wd;
    end

    // ------
    // Alarm codes
    // ------
    // A new alarm wins over a clear arriving in the same cycle
    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            alm_act_q  <= ALARM_NONE;
            alm_last_q <= ALARM_NONE;
        end
        else if (ALARM_VALID_IN)
        begin
            alm_act_q  <= ALARM_CODE_IN;
            alm_last_q <= ALARM_CODE_IN;
        end
        else if (c_alm_clr)
        begin
            alm_act_q  <= ALARM_NONE;
            alm_last_q <= ALARM_NONE;
        end
        else if (c_glob)
        begin
            if (is_cksum(alm_act_q))
                alm_act_q <= ALARM_NONE;
            if (is_cksum(alm_last_q))
                alm_last_q <= ALARM_NONE;
        end
    end

    // ------
    // Reference selection
    // ------
    logic signed [15:0] fs;
    logic signed [16:0] ana_ofs;
    logic signed [33:0] prod;
    logic signed [15:0] ana_ref;
    logic signed [15:0] user_ref;
    logic signed [15:0] sel_ref;

    always_comb
    begin
        fs       = ctrl_q[B_FS_SEL] ? par_q[P_FS_SECOND]
                                    : par_q[P_FS_FIRST];
        ana_ofs  = sx(ANALOG_REF_IN) + sx(par_q[P_REF_OFS]);
        prod     = 34'(ana_ofs * sx(fs)) >>> ANALOG_SHIFT;
        ana_ref  = prod[15:0];
        if (!ctrl_q[B_DIG_REF])
            user_ref = ana_ref;
        else if (ctrl_q[B_IF_SEL])
            user_ref = FREQ_REF_IN;
        else
            user_ref = par_q[P_INT_REF];
        sel_ref  = ctrl_q[B_REF_SRC] ? RESERVED_REF_IN
                                     : user_ref;
    end

    // ------
    // Applied reference: hold and stop ramp
    // ------
    logic stopping;

    assign stopping = ctrl_q[B_STOP]
                   || (ctrl_q[B_LEFT] && sel_ref < 0)
                   || (ctrl_q[B_RIGHT] && sel_ref > 0);

    always_comb
    begin
        case (state_q)
            ST_TRACK, ST_HOLD, ST_RAMP:
                if (stopping)
                    state_d = ST_RAMP;
                else if (ctrl_q[B_FREEZE])
                    state_d = ST_HOLD;
                else
                    state_d = ST_TRACK;
            default: state_d = ST_TRACK;
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
            state_q <= ST_TRACK;
        else
            state_q <= state_d;
    end

    // One tick per microsecond; a stop ramp value of N moves 1 rpm
    // every N ticks, i.e. N ms per 1000 rpm.
    assign tick = tick_cnt_q == TICK_W'(RAMP_TICK_CYC - 1);

    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
            tick_cnt_q <= '0;
        else if (tick)
            tick_cnt_q <= '0;
        else
            tick_cnt_q <= tick_cnt_q + 1'b1;
    end

    logic ramp_step;

    assign ramp_step = tick && (ramp_cnt_q + 1'b1 >= par_q[P_STOP_RAMP]);

    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
            ramp_cnt_q <= '0;
        else if (state_q != ST_RAMP || ramp_step)
            ramp_cnt_q <= '0;
        else if (tick)
            ramp_cnt_q <= ramp_cnt_q + 1'b1;
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
            ref_q <= '0;
        else
            case (state_q)
                ST_TRACK: ref_q <= sel_ref;
                ST_HOLD:  ref_q <= ref_q;
                ST_RAMP:
                    if (ramp_step && ref_q > 0)
                        ref_q <= ref_q - 16'sh0001;
                    else if (ramp_step && ref_q < 0)
                        ref_q <= ref_q + 16'sh0001;
                default:  ref_q <= '0;
            endcase
    end
    assign SPEED_REF_OUT = ref_q;

    // ------
    // Speed status
    // ------
    logic signed [16:0] cmp_q;

    always_comb
    begin
        cmp_q = ctrl_q[B_WIN_MODE] ? sx(MOTOR_SPEED_IN)
              : 17'(sx(MOTOR_SPEED_IN) - sx(ref_q));
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
            flags_q <= '0;
        else
        begin
            flags_q.at_speed   <= cmp_q < sx(par_q[P_WIN_UP])
                               && cmp_q > sx(par_q[P_WIN_LO]);
            flags_q.overspeed  <= mag(MOTOR_SPEED_IN)
                               > 17'(par_q[P_OVS_THR]);
            flags_q.zero_speed <= MOTOR_SPEED_IN == 0;
            flags_q.forward    <= MOTOR_SPEED_IN > 0;
        end
    end
    assign SPEED_FLAGS_OUT = flags_q;

    // ------
    // Outputs: run, aux, encoder, frequency input
    // ------
    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            run_q <= 1'b0;
            aux_q <= '0;
            enc_q <= '0;
        end
        else
        begin
            run_q <= START_REQ_IN && ctrl_q[B_SOFT_EN];
            aux_q <= ctrl_q[B_AUX_SEL] ? par_q[P_AUX_VAL]
                                       : TORQUE_IN;
            enc_q <= enc_lines({io_q[B_ENC0+2], io_q[B_ENC0+1],
                                io_q[B_ENC0]});
        end
    end
    assign DRIVE_RUN_OUT       = run_q;
    assign AUX_OUT             = aux_q;
    assign ENC_LINES_OUT       = enc_q;
    assign FREQ_QUADRATURE_OUT = io_q[B_FREQ_FMT];

endmodule : drive_binary_control_status

/* inc/drive_pkg.sv */
// Constants, types and register map of the drive binary control block
package drive_pkg;

    // ------
    // Timing
    // ------
    localparam int CLK_PERIOD_NS = 10;
    localparam int RAMP_TICK_NS  = 1000;
    localparam int RAMP_TICK_CYC = RAMP_TICK_NS / CLK_PERIOD_NS;
    localparam int TICK_W        = 8;

    // ------
    // Register byte offsets
    // ------
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_STATUS   = 8'h04;
    localparam logic [7:0] OFF_IOCFG    = 8'h08;
    localparam logic [7:0] OFF_FUNC     = 8'h0C;
    localparam logic [7:0] OFF_SYS      = 8'h10;
    localparam logic [7:0] OFF_PAR_BASE = 8'h14;
    localparam logic [7:0] OFF_ALM_ACT  = 8'h38;
    localparam logic [7:0] OFF_ALM_LAST = 8'h3C;
    localparam int         NUM_PAR      = 9;

    // Parameter indices
    localparam int P_FS_FIRST  = 0;
    localparam int P_FS_SECOND = 1;
    localparam int P_INT_REF   = 2;
    localparam int P_STOP_RAMP = 3;
    localparam int P_OVS_THR   = 4;
    localparam int P_WIN_UP    = 5;
    localparam int P_WIN_LO    = 6;
    localparam int P_AUX_VAL   = 7;
    localparam int P_REF_OFS   = 8;

    localparam logic [15:0] PAR_DEFAULT [NUM_PAR] = '{
        16'h03E8, 16'h03E8, 16'h0000, 16'h0002, 16'h0DAC,
        16'h0014, 16'hFFEC, 16'h0000, 16'h0000};

    // ------
    // Field positions
    // ------
    localparam int B_FS_SEL    = 0;
    localparam int B_REF_SRC   = 2;
    localparam int B_FREEZE    = 3;
    localparam int B_LEFT      = 4;
    localparam int B_RIGHT     = 5;
    localparam int B_STOP      = 6;
    localparam int B_WIN_MODE  = 7;
    localparam int B_SOFT_EN   = 9;
    localparam int B_AUX_SEL   = 11;
    localparam int B_DIG_REF   = 12;
    localparam int B_IF_SEL    = 13;
    localparam int B_ENC0      = 0;
    localparam int B_REINIT    = 3;
    localparam int B_DOUT_OC   = 4;
    localparam int B_FREQ_FMT  = 5;
    localparam int B_OFS_ZERO  = 1;
    localparam int B_EXT_MENU  = 6;
    localparam int B_EDIT_LOCK = 7;
    localparam int B_ALM_CLR   = 10;
    localparam int B_MODE_DEF  = 11;
    localparam int B_GLOB_DEF  = 12;
    localparam int B_PLC_RUN   = 13;
    localparam int B_STORE_PRG = 14;
    localparam int B_STORE_PAR = 15;
    localparam int B_HEALTHY   = 4;
    localparam int B_ENABLED   = 12;

    // Reset values and writable masks
    localparam logic [15:0] CTRL_RESET = 16'h0200;
    localparam logic [15:0] CTRL_WMASK = 16'h7FFF;
    localparam logic [15:0] IO_RESET   = 16'h0020;
    localparam logic [15:0] IO_WMASK   = 16'h0067;
    localparam logic [15:0] SYS_RESET  = 16'h2000;
    localparam logic [15:0] SYS_WMASK  = 16'h21C0;

    // ------
    // Codes and scaling
    // ------
    localparam logic [7:0]  ALARM_NONE    = 8'h00;
    localparam logic [7:0]  ALARM_CKS_PLC = 8'h0A;
    localparam logic [7:0]  ALARM_CKS_PAR = 8'h0B;
    localparam logic [15:0] OFS_LIMIT_MV  = 16'h00C8;
    localparam int          ANALOG_SHIFT  = 14;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic forward;
        logic zero_speed;
        logic at_speed;
        logic overspeed;
    } speed_flags_type;

    typedef struct packed {
        logic serial_reinit;
        logic mode_defaults;
        logic global_defaults;
        logic store_program;
        logic store_params;
    } cmd_pulse_type;

    typedef enum logic [1:0] {
        ST_TRACK = 2'h0,
        ST_HOLD  = 2'h1,
        ST_RAMP  = 2'h3
    } ref_state_type;

endpackage : drive_pkg

/* test/drive_ctrl_monitor.sv */
// Port-level checker of the drive control block
`timescale 1ns/100ps
module drive_ctrl_monitor
    import drive_pkg::*;
(
    input wire logic               CLK_IN,
    input wire logic               RSTN_IN,
    input wire logic [1:0]         HTRANS_IN,
    input wire logic               HWRITE_IN,
    input wire logic [31:0]        HRDATA_OUT,
    input wire logic               HREADYOUT_OUT,
    input wire logic               HRESP_OUT,
    input wire logic signed [15:0] MOTOR_SPEED_IN,
    input wire logic               START_REQ_IN,
    input wire logic               DRIVE_RUN_OUT,
    input wire logic [12:0]        ENC_LINES_OUT,
    input wire speed_flags_type    SPEED_FLAGS_OUT,
    input wire cmd_pulse_type      CMD_PULSE_OUT
);
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RSTN_IN);

    chk_bus_okay: assert property (HREADYOUT_OUT && !HRESP_OUT)
        else $error("bus stalled or errored");
    chk_read_upper: assert property (HRDATA_OUT[31:16] == 16'h0000)
        else $error("read data upper half set");
    chk_run_gate: assert property (!START_REQ_IN |=> !DRIVE_RUN_OUT)
        else $error("drive runs without start");
    chk_zero_flag: assert property ($past(RSTN_IN) |->
        SPEED_FLAGS_OUT.zero_speed == ($past(MOTOR_SPEED_IN) == 16'sh0))
        else $error("zero speed flag wrong");
    chk_fwd_flag: assert property ($past(RSTN_IN) |->
        SPEED_FLAGS_OUT.forward == ($past(MOTOR_SPEED_IN) > 16'sh0))
        else $error("forward flag wrong");
    chk_ovs_idle: assert property ($past(RSTN_IN) &&
        $past(MOTOR_SPEED_IN) == 16'sh0 |-> !SPEED_FLAGS_OUT.overspeed)
        else $error("overspeed at standstill");
    // Pulses only follow a taken write, two edges after its address phase
    chk_cmd_source: assert property (|CMD_PULSE_OUT |->
        $past(HTRANS_IN[1], 2) && $past(HWRITE_IN, 2))
        else $error("command pulse without write");
    chk_enc_codes: assert property (ENC_LINES_OUT inside
        {13'h0000, 13'h1000, 13'h0800, 13'h0400, 13'h0200, 13'h0100,
         13'h0080})
        else $error("encoder line count illegal");
    cover property (SPEED_FLAGS_OUT.at_speed);
    cover property (|CMD_PULSE_OUT);
    cover property (DRIVE_RUN_OUT);
endmodule : drive_ctrl_monitor

bind drive_binary_control_status drive_ctrl_monitor u_mon (.CLK_IN,
    .RSTN_IN, .HTRANS_IN, .HWRITE_IN, .HRDATA_OUT, .HREADYOUT_OUT,
    .HRESP_OUT, .MOTOR_SPEED_IN, .START_REQ_IN, .DRIVE_RUN_OUT,
    .ENC_LINES_OUT, .SPEED_FLAGS_OUT, .CMD_PULSE_OUT);

/* test/tb_drive_binary_control_status.sv */
// Self-checking bench of the drive control block
`timescale 1ns/100ps
module tb_drive_binary_control_status import drive_pkg::*;;
    logic               CLK_IN = 1'b0, RSTN_IN = 1'b0, HSEL_IN = 1'b1;
    logic               HWRITE_IN = 1'b0, ALARM_VALID_IN = 1'b0;
    logic               START_REQ_IN = 1'b0, DOUT_OVERCURRENT_IN = 1'b0;
    logic [1:0]         HTRANS_IN = 2'h0;
    logic [2:0]         HSIZE_IN = 3'h2;
    logic [7:0]         ALARM_CODE_IN = 8'h00;
    logic [31:0]        HADDR_IN = 32'h0, HWDATA_IN = 32'h0, HRDATA_OUT, rd;
    logic signed [15:0] ANALOG_REF_IN = 16'sh0, FREQ_REF_IN = 16'sh0;
    logic signed [15:0] RESERVED_REF_IN = 16'sh0, MOTOR_SPEED_IN = 16'sh0;
    logic signed [15:0] TORQUE_IN = 16'sh0, OFFSET_MV_IN = 16'sh0;
    logic signed [15:0] SPEED_REF_OUT, AUX_OUT;
    logic               HREADYOUT_OUT, HRESP_OUT, DRIVE_RUN_OUT;
    logic               FREQ_QUADRATURE_OUT;
    logic [12:0]        ENC_LINES_OUT;
    speed_flags_type    SPEED_FLAGS_OUT;
    cmd_pulse_type      CMD_PULSE_OUT, pl;
    wire logic          HREADY_IN = HREADYOUT_OUT;
    int                 num_errors = 0, check_count = 0;

    drive_binary_control_status u_dut (.*);
    initial forever #5 CLK_IN = ~CLK_IN;

    // -------------
    // Bench helpers
    // -------------
    task automatic conclude();
        if (num_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [31:0] e, g);
        check_count++;
        if (e !== g)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Bounded wait for hready; a hang ends the run as a failure
    task automatic step();
        for (int n = 0; n < 20; n++)
        begin
            @(posedge CLK_IN);
            if (HREADY_IN === 1'b1)
                return;
        end
        num_errors++;
        conclude();
    endtask : step

    // One word transfer plus an idle cycle that catches the command pulse
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        HTRANS_IN <= HTRANS_NONSEQ;
        HWRITE_IN <= w;
        HADDR_IN <= {24'h0, a};
        step();
        HTRANS_IN <= 2'h0;
        HWDATA_IN <= {16'h0, d};
        step();
        rd = HRDATA_OUT;
        @(posedge CLK_IN);
        pl = CMD_PULSE_OUT;
    endtask : bus

    task automatic settle();
        repeat (3) @(posedge CLK_IN);
    endtask : settle

    task automatic raise(input logic [7:0] c);
        ALARM_CODE_IN <= c;
        ALARM_VALID_IN <= 1'b1;
        @(posedge CLK_IN);
        ALARM_VALID_IN <= 1'b0;
    endtask : raise

    function automatic speed_flags_type fl(input int m, input int w);
        return {m > 0, m == 0, w < 20 && w > -20, (m < 0 ? -m : m) > 3500};
    endfunction : fl

    // ---------
    // Scenarios
    // ---------
    initial
    begin
        int s;
        void'($urandom(58));
        repeat (3) @(posedge CLK_IN);
        RSTN_IN <= 1'b1;
        bus(0, OFF_CTRL, 0);
        chk("ctrl", 32'h0200, rd);
        bus(0, OFF_IOCFG, 0);
        chk("iocfg", 32'h0020, rd);
        chk("quad", 1'b1, FREQ_QUADRATURE_OUT);
        bus(0, 8'h40, 0);
        chk("unmapped", 32'h0, rd);
        for (int c = 0; c < 8; c++)
        begin
            bus(1, OFF_IOCFG, 16'(c));
            settle();
            chk("enc", c > 1 ? 32'h4000 >> c : 0, ENC_LINES_OUT);
        end
        chk("quad", 1'b0, FREQ_QUADRATURE_OUT);
        bus(1, OFF_CTRL, 16'h0280);
        for (int i = 0; i < 40; i++)
        begin
            s = int'($urandom_range(i % 2 ? 8000 : 80)) - (i % 2 ? 4000 : 40);
            if (i < 9)
                s = i == 8 ? 0 : (i % 2 ? -1 : 1) * (i < 4 ? 19 + i / 2 : 3498 + i / 2);
            MOTOR_SPEED_IN <= 16'(s);
            settle();
            chk("flags", fl(s, s), SPEED_FLAGS_OUT);
        end
        bus(1, OFF_PAR_BASE + 8'h08, 16'h0064);
        bus(1, OFF_CTRL, 16'h1200);
        MOTOR_SPEED_IN <= 16'sh006E;
        FREQ_REF_IN <= 16'($urandom_range(9000));
        settle();
        chk("ref", 32'h0064, SPEED_REF_OUT);
        chk("window", fl(110, 10), SPEED_FLAGS_OUT);
        bus(1, OFF_CTRL, 16'h3200);
        RESERVED_REF_IN <= -FREQ_REF_IN;
        settle();
        chk("freq", FREQ_REF_IN, SPEED_REF_OUT);
        bus(1, OFF_CTRL, 16'h3204);
        settle();
        chk("reserved", RESERVED_REF_IN, SPEED_REF_OUT);
        bus(1, OFF_SYS, 16'h2800);
        chk("modedef", 32'h0, pl);
        s = RESERVED_REF_IN;
        bus(1, OFF_CTRL, 16'h320C);
        RESERVED_REF_IN <= 16'(s + 7);
        settle();
        chk("hold", s, SPEED_REF_OUT);
        for (int i = 0; i < 5; i++)
        begin
            s = i % 2 ? -3 : 3;
            bus(1, OFF_CTRL, 16'h1200);
            bus(1, OFF_PAR_BASE + 8'h08, 16'(s));
            bus(1, OFF_CTRL, 16'h1200 | 16'h0010 << i / 2);
            repeat (350) @(posedge CLK_IN);
            chk("slope", 1'b1, SPEED_REF_OUT != 0);
            repeat (350) @(posedge CLK_IN);
            chk("ramp", i % 3 ? 0 : s, SPEED_REF_OUT);
        end
        TORQUE_IN <= 16'($urandom);
        bus(1, OFF_PAR_BASE + 8'h1C, 16'h0055);
        bus(1, OFF_CTRL, 16'h0200);
        START_REQ_IN <= 1'b1;
        settle();
        chk("aux", TORQUE_IN, AUX_OUT);
        chk("run", 1'b1, DRIVE_RUN_OUT);
        bus(1, OFF_CTRL, 16'h0800);
        settle();
        chk("aux", 32'h0055, AUX_OUT);
        chk("run", 1'b0, DRIVE_RUN_OUT);
        raise(8'h0B);
        bus(1, OFF_SYS, 16'h2400);
        bus(0, OFF_ALM_ACT, 0);
        chk("alarm", 32'h000B, rd);
        bus(1, OFF_SYS, 16'hE000);
        chk("store", 32'h0, pl);
        bus(1, OFF_SYS, 16'h0000);
        bus(1, OFF_SYS, 16'h1000);
        chk("globdef", 32'h04, pl);
        bus(0, OFF_ALM_ACT, 0);
        chk("alarm", 32'h0, rd);
        bus(1, OFF_SYS, 16'h0800);
        chk("modedef", 32'h08, pl);
        bus(1, OFF_SYS, 16'hC000);
        chk("store", 32'h03, pl);
        bus(1, OFF_SYS, 16'h0080);
        bus(1, OFF_SYS, 16'h8080);
        chk("locked", 32'h0, pl);
        bus(1, OFF_SYS, 16'h0000);
        bus(1, OFF_IOCFG, 16'h0008);
        chk("reinit", 32'h0, pl);
        bus(1, OFF_SYS, 16'h0040);
        bus(1, OFF_IOCFG, 16'h0008);
        chk("reinit", 32'h10, pl);
        bus(0, OFF_IOCFG, 0);
        chk("cmdbit", 32'h0, rd);
        raise(8'h03);
        bus(1, OFF_SYS, 16'h0400);
        bus(0, OFF_ALM_LAST, 0);
        chk("last", 32'h0, rd);
        bus(1, OFF_SYS, 16'h0040);
        OFFSET_MV_IN <= 16'sh00FA;
        bus(1, OFF_FUNC, 16'h0002);
        bus(0, OFF_PAR_BASE + 8'h20, 0);
        chk("ofsfar", 32'h0, rd);
        OFFSET_MV_IN <= -16'sh0032;
        bus(1, OFF_FUNC, 16'h0002);
        bus(0, OFF_PAR_BASE + 8'h20, 0);
        chk("ofszero", 32'h0032, rd);
        ANALOG_REF_IN <= 16'sh0064;
        bus(1, OFF_PAR_BASE + 8'h04, 16'h4000);
        bus(1, OFF_CTRL, 16'h0201);
        settle();
        chk("fullscale", 32'h0096, SPEED_REF_OUT);
        bus(1, OFF_CTRL, 16'h0200);
        settle();
        chk("fullscale", 32'h0009, SPEED_REF_OUT);
        conclude();
    end
endmodule : tb_drive_binary_control_status
